/* File: core/module_mgmt_control_timing.sv */
`timescale 1ns/100ps
`include "mgmt_consts.svh"

module module_mgmt_control_timing #(
   parameter int LANES = 4,
   parameter int N_OTHER = 4,
   parameter int FW = 1 + 2 * LANES + N_OTHER,
   parameter logic [31:0] INIT_CYC = `INIT_CYC,
   parameter logic [31:0] PDOWN_OFF_CYC = `PDOWN_OFF_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // host control pins
   input mgmt_pkg::host_pins_t pins,
   // monitored conditions
   input wire logic [LANES-1:0] rx_los_state,
   input wire logic [LANES-1:0] tx_fault_state,
   input wire logic [N_OTHER-1:0] other_state,
   // serial bus side: pulses at the falling clock edge after the stop bit
   input wire logic rd_done,
   input wire logic [FW-1:0] rd_clear,
   input mgmt_pkg::wr_strobe_t wr,
   input wire logic [FW-1:0] wr_mask,
   // status to host and to the module
   output logic interrupt_request_n,
   output logic serial_respond,
   output logic low_power,
   output logic fully_functional,
   output logic [7:0] status_byte2,
   output logic [FW-1:0] flags,
   output logic [FW-1:0] mask
);
   import mgmt_pkg::*;

   localparam logic [7:0] RST_MIN = 8'(`RST_MIN_CYC);

   typedef struct packed {
      phase_t phase;
      logic [31:0] cnt;
      logic [7:0] low_cnt;
      logic [FW-1:0] flags;
      logic [FW-1:0] mask;
      logic [FW-1:0] cond_q;
      logic [31:0] settle;
      logic int_n;
      logic serial;
      logic pdown;
      logic lp;
      logic full;
      logic nready;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [FW-1:0] cond;
   logic [FW-1:0] events;
   logic [FW-1:0] clr;
   logic event_any;

   // bit 0 is the ready flag; it has no external condition
   assign cond = {other_state, tx_fault_state, rx_los_state, 1'b0};

   always_comb begin
      st_next = st_reg;
      events = '0;
      clr = '0;

      // a low pin is only a reset once it has stood for the minimum time;
      // shorter glitches are ignored so noise cannot restart the module
      if (!pins.module_reset_low) begin
         if (st_reg.low_cnt != RST_MIN) begin
            st_next.low_cnt = st_reg.low_cnt + 8'h01;
         end
      end else begin
         st_next.low_cnt = 8'h00;
      end

      unique case (st_reg.phase)
         ST_RESET: begin
            if (pins.module_reset_low) begin
               st_next.phase = ST_INIT;
               st_next.cnt = 32'h0;
            end
         end
         ST_INIT: begin
            if (st_reg.cnt == INIT_CYC - 32'h1) begin
               st_next.phase = ST_RUN;
               events[`FLAG_READY_BIT] = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt + 32'h1;
            end
         end
         ST_RUN: begin
            // new conditions latch on their rising edge
            events = cond & ~st_reg.cond_q;
         end
      endcase

      if (!pins.module_reset_low && st_reg.low_cnt == RST_MIN - 8'h01) begin
         st_next.phase = ST_RESET;
         st_next.cnt = 32'h0;
      end

      st_next.cond_q = cond;

      if (rd_done) begin
         clr = rd_clear;
      end

      // a flag event in the clearing cycle wins over the clear
      if (st_next.phase == ST_RESET) begin
         st_next.flags = '0;
      end else begin
         st_next.flags = (st_reg.flags & ~clr) | events;
      end

      // writes take effect on the strobe itself
      if (wr.done && wr.mask_en) begin
         st_next.mask = wr_mask;
      end
      if (wr.done && wr.pdown_en) begin
         st_next.pdown = wr.pdown;
      end

      st_next.lp = pins.low_power_select | st_next.pdown;

      // after leaving low power the optics need time to settle
      if (st_next.lp) begin
         st_next.settle = PDOWN_OFF_CYC;
      end else if (st_reg.settle != 32'h0) begin
         st_next.settle = st_reg.settle - 32'h1;
      end

      st_next.nready = (st_next.phase != ST_RUN);
      st_next.full = (st_next.phase == ST_RUN) && !st_next.lp && (st_next.settle == 32'h0);

      // the bus is silent until init ends and while deselected; gating on the next phase
      // drops the answer and the interrupt in the very edge that a pin reset is taken
      st_next.serial = (st_next.phase == ST_RUN) && !pins.module_select_n;

      if (st_next.phase == ST_RUN) begin
         st_next.int_n = ~|(st_reg.flags & ~st_reg.mask);
      end else begin
         st_next.int_n = 1'b1;
      end
   end

   assign event_any = |events;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_reg.phase <= ST_INIT;
         st_reg.cnt <= 32'h0;
         st_reg.low_cnt <= 8'h00;
         st_reg.flags <= '0;
         st_reg.mask <= {FW{`MASK_RST}};
         st_reg.cond_q <= '0;
         st_reg.settle <= 32'h0;
         st_reg.int_n <= 1'b1;
         st_reg.serial <= 1'b0;
         st_reg.pdown <= `PDOWN_RST;
         st_reg.lp <= 1'b0;
         st_reg.full <= 1'b0;
         st_reg.nready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign interrupt_request_n = st_reg.int_n;
   assign serial_respond = st_reg.serial;
   assign low_power = st_reg.lp;
   assign fully_functional = st_reg.full;
   assign flags = st_reg.flags;
   assign mask = st_reg.mask;

   always_comb begin
      status_byte2 = 8'h00;
      status_byte2[`STATUS_NOT_READY_BIT] = st_reg.nready;
   end

   property p_reset_qualify;
      @(posedge mclk) disable iff (!nrst)
      (!pins.module_reset_low && st_reg.low_cnt == RST_MIN - 8'h01)
         |=> (st_reg.phase == ST_RESET) && status_byte2[0] && interrupt_request_n;
   endproperty
   a_reset_qualify: assert property (p_reset_qualify) else $error("reset pulse not taken");

   property p_init_done;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_INIT && st_reg.cnt == INIT_CYC - 32'h1 && pins.module_reset_low)
         |=> (st_reg.phase == ST_RUN) && !status_byte2[0] && st_reg.flags[0];
   endproperty
   a_init_done: assert property (p_init_done) else $error("init did not end on time");

   property p_not_ready;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase != ST_RUN) |-> status_byte2[0] && interrupt_request_n && !serial_respond;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("ready shown before init end");

   property p_ready_int;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_INIT && st_reg.cnt == INIT_CYC - 32'h1 && pins.module_reset_low
         && !st_reg.mask[0] && !(wr.done && wr.mask_en)) |=> ##1 !interrupt_request_n;
   endproperty
   a_ready_int: assert property (p_ready_int) else $error("no interrupt at ready");

   property p_los_int;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_RUN && pins.module_reset_low && rx_los_state[0]
         && !st_reg.cond_q[1] && !st_reg.mask[1] && !(wr.done && wr.mask_en))
         |=> st_reg.flags[1] ##1 !interrupt_request_n;
   endproperty
   a_los_int: assert property (p_los_int) else $error("loss flag not raised");

   property p_fault_int;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_RUN && pins.module_reset_low && tx_fault_state[0]
         && !st_reg.cond_q[1 + LANES] && !st_reg.mask[1 + LANES] && !(wr.done && wr.mask_en))
         |=> st_reg.flags[1 + LANES] ##1 !interrupt_request_n;
   endproperty
   a_fault_int: assert property (p_fault_int) else $error("fault flag not raised");

   property p_clear_release;
      @(posedge mclk) disable iff (!nrst)
      (rd_done && ((st_reg.flags & ~rd_clear & ~st_reg.mask) == '0) && !event_any
         && !(wr.done && wr.mask_en)) |=> ##1 interrupt_request_n;
   endproperty
   a_clear_release: assert property (p_clear_release) else $error("interrupt held after read");

   property p_mask_inhibit;
      @(posedge mclk) disable iff (!nrst)
      (wr.done && wr.mask_en && ((st_reg.flags & ~wr_mask) == '0) && !event_any)
         |=> ##1 interrupt_request_n;
   endproperty
   a_mask_inhibit: assert property (p_mask_inhibit) else $error("mask did not inhibit");

   property p_int_cause;
      @(posedge mclk) disable iff (!nrst)
      !interrupt_request_n |-> $past(|(st_reg.flags & ~st_reg.mask));
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("interrupt without flag");

   property p_low_power;
      @(posedge mclk) disable iff (!nrst)
      (pins.low_power_select || (wr.done && wr.pdown_en && wr.pdown))
         |=> low_power && !fully_functional;
   endproperty
   a_low_power: assert property (p_low_power) else $error("low power not entered");

   property p_select;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_RUN)
         |=> (serial_respond == (!$past(pins.module_select_n) && st_reg.phase == ST_RUN));
   endproperty
   a_select: assert property (p_select) else $error("bus answer wrong for select");

   property p_deselect;
      @(posedge mclk) disable iff (!nrst)
      (st_reg.phase == ST_RUN && pins.module_select_n) |=> !serial_respond;
   endproperty
   a_deselect: assert property (p_deselect) else $error("bus answered while deselected");

   property p_mask_resume;
      @(posedge mclk) disable iff (!nrst)
      (wr.done && wr.mask_en && !rd_done && st_reg.phase == ST_RUN && pins.module_reset_low
         && |(st_reg.flags & ~wr_mask)) |=> ##1 !interrupt_request_n;
   endproperty
   a_mask_resume: assert property (p_mask_resume) else $error("unmask did not resume");

   // only meaningful while the settle count is two or more
   property p_settle;
      @(posedge mclk) disable iff (!nrst)
      $fell(low_power) |-> !fully_functional;
   endproperty
   a_settle: assert property (p_settle) else $error("full function before settle");

   property p_flag_hold;
      @(posedge mclk) disable iff (!nrst)
      (pins.module_reset_low && !rd_done)
         |=> ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags));
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");
endmodule

/* File: shared/mgmt_consts.svh */
`ifndef MGMT_CONSTS_SVH
`define MGMT_CONSTS_SVH

// clock rate and derived cycle counts
`define CLK_MHZ 50
`define T_INIT_MS 2000
`define INIT_CYC (`T_INIT_MS * 1000 * `CLK_MHZ)
`define T_RESET_MIN_US 2
`define RST_MIN_CYC (`T_RESET_MIN_US * `CLK_MHZ)
`define T_PDOWN_OFF_MS 300
`define PDOWN_OFF_CYC (`T_PDOWN_OFF_MS * 1000 * `CLK_MHZ)

// field positions
`define STATUS_NOT_READY_BIT 0
`define FLAG_READY_BIT 0

// reset values
`define MASK_RST 1'b0
`define PDOWN_RST 1'b0

`endif

/* File: shared/mgmt_pkg.sv */
package mgmt_pkg;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } phase_t;

   typedef struct packed {
      logic module_reset_low;
      logic module_select_n;
      logic low_power_select;
   } host_pins_t;

   typedef struct packed {
      logic done;
      logic mask_en;
      logic pdown_en;
      logic pdown;
   } wr_strobe_t;

endpackage

/* File: verif/host_mgmt_ctrl.sv */
`timescale 1ns/100ps
module host_mgmt_ctrl #(
   parameter int FW = 13
) (
   // clock
   input wire logic mclk,
   // pins and serial bus strobes toward the module
   output mgmt_pkg::host_pins_t pins,
   output logic rd_done,
   output logic [FW-1:0] rd_clear,
   output mgmt_pkg::wr_strobe_t wr,
   output logic [FW-1:0] wr_mask
);
   import mgmt_pkg::*;
   initial begin
      pins = 3'h6;
      rd_done = 1'b0;
      rd_clear = '0;
      wr = 4'h0;
      wr_mask = '0;
   end
   // strobe edge stands for the falling clock edge after the stop bit
   task automatic rd(input logic [FW-1:0] clr);
      @(posedge mclk);
      rd_done <= 1'b1;
      rd_clear <= clr;
      @(posedge mclk);
      rd_done <= 1'b0;
      rd_clear <= ~clr;
   endtask
   task automatic wrm(input logic [FW-1:0] m);
      @(posedge mclk);
      wr <= 4'hc;
      wr_mask <= m;
      @(posedge mclk);
      wr <= 4'h0;
      wr_mask <= ~m;
   endtask
   task automatic wrp(input logic p);
      @(posedge mclk);
      wr <= {3'h5, p};
      @(posedge mclk);
      wr <= {3'h0, ~p};
   endtask
   task automatic set_sel(input logic v);
      @(posedge mclk);
      pins.module_select_n <= v;
   endtask
   task automatic set_lp(input logic v);
      @(posedge mclk);
      pins.low_power_select <= v;
   endtask
   task automatic pulse_reset(input int n);
      @(posedge mclk);
      pins.module_reset_low <= 1'b0;
      repeat (n) @(posedge mclk);
      pins.module_reset_low <= 1'b1;
   endtask
endmodule

/* File: verif/test_module_mgmt_control_timing.sv */
`timescale 1ns/100ps
module test_module_mgmt_control_timing;
   import mgmt_pkg::*;
   localparam int FW = 13;
   localparam int LIM = 1000;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   host_pins_t pins;
   wr_strobe_t wr;
   logic rd_done;
   logic [FW-1:0] rd_clear, wr_mask, flags, mask;
   logic [3:0] rx_los_state;
   logic [3:0] tx_fault_state;
   logic [3:0] other_state;
   logic interrupt_request_n, serial_respond, low_power, fully_functional;
   logic [7:0] status_byte2;
   int fails = 0;
   int cmp_count = 0;
   // 3 interrupt, 2 bus answer, 1 low power, 0 fully functional
   wire [3:0] obs = {interrupt_request_n, serial_respond, low_power, fully_functional};
   always #10 mclk = ~mclk;
   module_mgmt_control_timing #(.INIT_CYC(32'hc8), .PDOWN_OFF_CYC(32'h32)) i_dut (
      .mclk(mclk), .nrst(nrst), .pins(pins), .rx_los_state(rx_los_state),
      .tx_fault_state(tx_fault_state), .other_state(other_state), .rd_done(rd_done),
      .rd_clear(rd_clear), .wr(wr), .wr_mask(wr_mask),
      .interrupt_request_n(interrupt_request_n), .serial_respond(serial_respond),
      .low_power(low_power), .fully_functional(fully_functional),
      .status_byte2(status_byte2), .flags(flags), .mask(mask));
   host_mgmt_ctrl #(.FW(FW)) i_host (.mclk(mclk), .pins(pins), .rd_done(rd_done),
      .rd_clear(rd_clear), .wr(wr), .wr_mask(wr_mask));
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // bounded wait; latencies are far inside the documented maxima
   task automatic wait_obs(input int idx, input logic v, input string name);
      int n;
      n = 0;
      while (obs[idx] !== v && n < LIM) begin
         @(negedge mclk);
         n++;
      end
      chk(name, {15'h0, v}, {15'h0, obs[idx]});
   endtask
   task automatic t_init;
      chk("status", 16'h0001, {8'h0, status_byte2});
      wait_obs(3, 1'b0, "int_ready");
      chk("status", 16'h0000, {8'h0, status_byte2});
      chk("flags", 16'h0001, {3'h0, flags});
      i_host.set_sel(1'b0);
      wait_obs(2, 1'b1, "respond");
      wait_obs(0, 1'b1, "ready");
      i_host.rd(13'h0001);
      wait_obs(3, 1'b1, "int_clear");
   endtask
   task automatic t_flags;
      @(posedge mclk);
      rx_los_state <= 4'hf;
      wait_obs(3, 1'b0, "int_los");
      chk("flags", 16'h001e, {3'h0, flags});
      i_host.rd(13'h001e);
      wait_obs(3, 1'b1, "int_los_clr");
      chk("flags", 16'h0000, {3'h0, flags});
      @(posedge mclk);
      tx_fault_state <= 4'hf;
      other_state <= 4'he;
      wait_obs(3, 1'b0, "int_fault");
      chk("flags", 16'h1de0, {3'h0, flags});
      i_host.rd(13'h01e0);
      repeat (4) @(negedge mclk);
      chk("int_held", 16'h0000, {15'h0, interrupt_request_n});
      chk("flags", 16'h1c00, {3'h0, flags});
      i_host.rd(13'h1c00);
      wait_obs(3, 1'b1, "int_other_clr");
   endtask
   task automatic t_mask;
      i_host.wrm(13'h0200);
      repeat (2) @(negedge mclk);
      chk("mask", 16'h0200, {3'h0, mask});
      @(posedge mclk);
      other_state <= 4'hf;
      repeat (4) @(negedge mclk);
      chk("flags", 16'h0200, {3'h0, flags});
      chk("int_masked", 16'h0001, {15'h0, interrupt_request_n});
      i_host.wrm(13'h0000);
      wait_obs(3, 1'b0, "int_unmask");
      i_host.wrm(13'h0200);
      wait_obs(3, 1'b1, "int_remask");
      i_host.wrm(13'h0000);
      wait_obs(3, 1'b0, "int_unmask2");
      i_host.rd(13'h0200);
      wait_obs(3, 1'b1, "int_mask_clr");
   endtask
   task automatic t_power;
      i_host.set_lp(1'b1);
      wait_obs(1, 1'b1, "lowp_pin");
      chk("ff", 16'h0000, {15'h0, fully_functional});
      i_host.set_lp(1'b0);
      repeat (4) @(negedge mclk);
      chk("ff_settle", 16'h0000, {15'h0, fully_functional});
      wait_obs(0, 1'b1, "ff_pin");
      i_host.wrp(1'b1);
      wait_obs(1, 1'b1, "lowp_ovr");
      i_host.wrp(1'b0);
      wait_obs(1, 1'b0, "lowp_off");
      wait_obs(0, 1'b1, "ff_ovr");
   endtask
   task automatic t_select;
      i_host.set_sel(1'b1);
      wait_obs(2, 1'b0, "resp_off");
      i_host.set_sel(1'b0);
      wait_obs(2, 1'b1, "resp_on");
   endtask
   task automatic t_reset;
      i_host.pulse_reset(50);
      repeat (4) @(negedge mclk);
      chk("resp_short", 16'h0001, {15'h0, serial_respond});
      i_host.pulse_reset(120);
      @(negedge mclk);
      chk("status", 16'h0001, {8'h0, status_byte2});
      chk("resp", 16'h0000, {15'h0, serial_respond});
      wait_obs(3, 1'b0, "int_reinit");
      wait_obs(2, 1'b1, "resp_reinit");
      i_host.rd(13'h0001);
      wait_obs(3, 1'b1, "int_reinit_clr");
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      rx_los_state <= 4'h0;
      tx_fault_state <= 4'h0;
      other_state <= 4'h0;
      repeat (16) @(posedge mclk);
      chk("int_rst", 16'h0001, {15'h0, interrupt_request_n});
      chk("flags_rst", 16'h0000, {3'h0, flags});
      nrst <= 1'b1;
      t_init;
      t_flags;
      t_mask;
      t_power;
      t_select;
      t_reset;
      final_report;
   end
   // hang guard: ample over the fewer than a thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge mclk);
      fails++;
      final_report;
   end
endmodule
